// File: core/cassette_regs.vh
// Purpose: Constants for the memory cassette transfer and compare block.
// Assumes: Included by bare name from the design files under core/.
// Notes:   Register offsets are word indices on the plain register port.
`ifndef CASSETTE_REGS_VH
`define CASSETTE_REGS_VH

// Register indices
`define REG_CTRL        4'h0
`define REG_STAT        4'h1
`define REG_SETUP       4'h2

// Control register bits
`define CTRL_WRITE      0
`define CTRL_READ       1
`define CTRL_COMPARE    2

// Status register bits
`define STAT_BUSY       0
`define STAT_MISMATCH   1
`define STAT_PROTECT    2
`define STAT_REFUSED    3
`define STAT_EPROM      4
`define STAT_PRESENT    5
`define STAT_SIZE_LO    6
`define STAT_SIZE_HI    7

// Setup register fields
`define SETUP_PER_LO    0
`define SETUP_PER_HI    1
`define SETUP_SER_LO    2
`define SETUP_SER_HI    3

// Port mode encodings
`define MODE_HOST       2'h0
`define MODE_NOPROTO    2'h1
`define MODE_DATALINK   2'h2
`define MODE_TERMLINK   2'h3

// Image areas in controller word addresses
`define PROG_BASE       16'h0000
`define DM_RO_FIRST     16'd6144
`define DM_RO_LAST      16'd6568
`define DM_SETUP_FIRST  16'd6600
`define DM_SETUP_LAST   16'd6655
`define DM_BASE         16'h8000
`define EXP_BASE        16'hF000

// EPROM capacities in words
`define EPROM_8K        17'd8192
`define EPROM_16K       17'd16384
`define EPROM_32K       17'd32768

// Timing in ns, sync stage and boot settle counts, reset data word
`define CLK_PERIOD_NS   50
`define CAS_ACCESS_NS   150
`define CAS_WRITE_NS    200
`define SYNC_STAGES     2
`define BOOT_SETTLE     3
`define RESET_DATA      16'h0000

`endif

// File: core/cassette_transfer_control.v
// Purpose: Batch write, read and compare of the stored image against a cassette.
// Assumes: Controller memory answers a read one cycle after the strobe; cassette
//          pins are asynchronous and pass the two-stage synchroniser.
// Notes:   One request at a time; request bits clear when the work is done.
`timescale 1ns/1ps
`include "cassette_regs.vh"
module cassette_transfer_control #(
   parameter PROG_WORDS = 16'd15360,
   parameter EXP_WORDS  = 16'd64,
   parameter CAS_WORDS  = 17'd16384
) (
   // Clock and reset
   input  wire        ref_clk,
   input  wire        rst,
   // Register port
   input  wire [3:0]  regAddr,
   input  wire [15:0] regWrData,
   input  wire        regWr,
   input  wire        regRd,
   output wire [15:0] regRdData,
   // Controller memory
   output wire [15:0] memAddr,
   output wire [15:0] memWrData,
   output wire        memWr,
   output wire        memRd,
   input  wire [15:0] memRdData,
   // Cassette memory pins
   output wire [14:0] casAddr,
   output wire [15:0] casWrData,
   output wire        casWrEn,
   output wire        casRdEn,
   input  wire [15:0] casRdData,
   // Cassette straps and switches
   input  wire        casPresent,
   input  wire        casProtectSw,
   input  wire        casIsEprom,
   input  wire        epromSizeSelectA,
   input  wire        epromSizeSelectB,
   // Front panel switches
   input  wire        autoLoadSwitch,
   input  wire        peripheralDeviceSwitch,
   // Port modes and status
   output wire        periphConsoleBus,
   output wire [1:0]  periphMode,
   output wire [1:0]  serialMode,
   output wire        busy
);

   // Cycle counts from times, rounded up; reads add the sync stages and a spare edge
   localparam integer CAS_RD_NUM = (`CAS_ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
   localparam integer CAS_WR_NUM = (`CAS_WRITE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
   localparam integer RD_NUM     = CAS_RD_NUM + `SYNC_STAGES + 1;
   localparam [3:0]   CAS_WR_CYC = CAS_WR_NUM[3:0];
   localparam [3:0]   RD_WAIT    = RD_NUM[3:0];

   // One-hot states
   localparam [5:0] S_IDLE = 6'h01;
   localparam [5:0] S_READ = 6'h02;
   localparam [5:0] S_WAIT = 6'h04;
   localparam [5:0] S_ACT  = 6'h08;
   localparam [5:0] S_CWR  = 6'h10;
   localparam [5:0] S_NEXT = 6'h20;

   // Operation codes held while busy
   localparam [1:0] OP_WRITE   = 2'h0;
   localparam [1:0] OP_READ    = 2'h1;
   localparam [1:0] OP_COMPARE = 2'h2;

   wire [22:0] pinsRaw;
   wire [22:0] pinsSync;

   wire [15:0] walkCtrlAddr;
   wire [14:0] walkCasAddr;
   wire        walkLast;
   wire [16:0] imageWords;

   reg  [5:0]  state_q;
   reg  [5:0]  state_d;
   reg  [1:0]  op_q;
   reg  [15:0] idx_q;
   reg  [3:0]  timer_q;
   reg  [2:0]  ctrlReq_q;
   reg         mismatch_q;
   reg         refused_q;
   reg  [3:0]  setup_q;
   reg  [15:0] rdData_q;
   reg  [15:0] memWord_q;
   reg  [15:0] casWord_q;
   reg         memRdPend_q;
   reg  [1:0]  bootCnt_q;
   reg         bootArm_q;

   reg  [15:0] memAddr_q;
   reg  [15:0] memWrData_q;
   reg         memWr_q;
   reg         memRd_q;
   reg  [14:0] casAddr_q;
   reg  [15:0] casWrData_q;
   reg         casWrEn_q;
   reg         casRdEn_q;

   reg  [16:0] capacity;
   reg         startOk;
   reg         startWr;
   reg         startRd;
   reg         startCmp;
   reg         refuse;

   // All pins from the cassette and panel cross into ref_clk here
   assign pinsRaw = {peripheralDeviceSwitch, autoLoadSwitch,
                     epromSizeSelectB, epromSizeSelectA, casIsEprom,
                     casProtectSw, casPresent, casRdData};

   sync_bits #(
      .WIDTH (23)
   ) u_sync (
      .ref_clk (ref_clk),
      .rst     (rst),
      .pinIn   (pinsRaw),
      .syncOut (pinsSync)
   );

   // Settled pin levels; only the second stage is read
   wire [15:0] casData  = pinsSync[15:0];
   wire        present  = pinsSync[16];
   wire        protect  = pinsSync[17];
   wire        isEprom  = pinsSync[18];
   wire        sizeA    = pinsSync[19];
   wire        sizeB    = pinsSync[20];
   wire        autoLoad = pinsSync[21];
   wire        perSw    = pinsSync[22];

   image_walker #(
      .PROG_WORDS (PROG_WORDS),
      .EXP_WORDS  (EXP_WORDS)
   ) u_walk (
      .wordIdx    (idx_q),
      .ctrlAddr   (walkCtrlAddr),
      .casAddr    (walkCasAddr),
      .lastWord   (walkLast),
      .imageWords (imageWords)
   );

   // Capacity from the size switches; the undefined code counts as smallest
   always @* begin
      if (!isEprom) begin
         capacity = CAS_WORDS;
      end else if (sizeA && sizeB) begin
         capacity = `EPROM_32K;
      end else if (sizeA) begin
         capacity = `EPROM_16K;
      end else begin
         capacity = `EPROM_8K;
      end
   end

   // Pick one request; write first, then read, then compare
   always @* begin
      startWr  = 1'b0;
      startRd  = 1'b0;
      startCmp = 1'b0;
      refuse   = 1'b0;
      startOk  = present && (imageWords <= capacity);
      if (state_q == S_IDLE) begin
         if (ctrlReq_q[`CTRL_WRITE]) begin
            // Protected or one-time cassettes are never written
            if (startOk && !protect && !isEprom) begin
               startWr = 1'b1;
            end else begin
               refuse = 1'b1;
            end
         end else if (ctrlReq_q[`CTRL_READ]) begin
            startRd = startOk;
            refuse  = !startOk;
         end else if (ctrlReq_q[`CTRL_COMPARE]) begin
            startCmp = startOk;
            refuse   = !startOk;
         end
      end
   end

   // Next state
   always @* begin
      state_d = state_q;
      case (state_q)
         S_IDLE: begin
            if (startWr || startRd || startCmp) begin
               state_d = S_READ;
            end
         end
         S_READ: state_d = S_WAIT;
         S_WAIT: begin
            if (timer_q == 4'h0) begin
               state_d = S_ACT;
            end
         end
         S_ACT: begin
            if (op_q == OP_WRITE) begin
               state_d = S_CWR;
            end else begin
               state_d = S_NEXT;
            end
         end
         S_CWR: begin
            if (timer_q == 4'h0) begin
               state_d = S_NEXT;
            end
         end
         S_NEXT: begin
            if (walkLast) begin
               state_d = S_IDLE;
            end else begin
               state_d = S_READ;
            end
         end
         default: state_d = S_IDLE;
      endcase
   end

   // Sequencer, word buffers and strobes
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state_q     <= S_IDLE;
         op_q        <= OP_READ;
         idx_q       <= 16'h0000;
         timer_q     <= 4'h0;
         memWord_q   <= `RESET_DATA;
         casWord_q   <= `RESET_DATA;
         memRdPend_q <= 1'b0;
         memAddr_q   <= 16'h0000;
         memWrData_q <= `RESET_DATA;
         memWr_q     <= 1'b0;
         memRd_q     <= 1'b0;
         casAddr_q   <= 15'h0000;
         casWrData_q <= `RESET_DATA;
         casWrEn_q   <= 1'b0;
         casRdEn_q   <= 1'b0;
         mismatch_q  <= 1'b0;
      end else begin
         state_q     <= state_d;
         memAddr_q   <= walkCtrlAddr;
         casAddr_q   <= walkCasAddr;
         memRd_q     <= (state_q == S_READ) && (op_q != OP_READ);
         memRdPend_q <= memRd_q;
         memWr_q     <= (state_q == S_ACT) && (op_q == OP_READ);
         casWrEn_q   <= (state_d == S_CWR);
         // Cassette outputs stay enabled until its data is captured
         casRdEn_q   <= (state_d == S_READ) || (state_d == S_WAIT);
         if (memRdPend_q) begin
            memWord_q <= memRdData;
         end
         if (state_q == S_IDLE) begin
            idx_q <= 16'h0000;
            if (startWr) begin
               op_q <= OP_WRITE;
            end else if (startRd) begin
               op_q <= OP_READ;
            end else if (startCmp) begin
               op_q       <= OP_COMPARE;
               mismatch_q <= 1'b0;         // Fresh result per compare
            end
         end
         if (state_q == S_READ) begin
            timer_q <= RD_WAIT;
         end else if (state_q == S_ACT) begin
            timer_q <= CAS_WR_CYC - 4'd1;
         end else if (timer_q != 4'h0) begin
            timer_q <= timer_q - 4'd1;
         end
         if ((state_q == S_WAIT) && (timer_q == 4'h0)) begin
            casWord_q <= casData;
         end
         if (state_q == S_ACT) begin
            memWrData_q <= casWord_q;
            casWrData_q <= memWord_q;
            // Compare touches neither copy, only the flag
            if ((op_q == OP_COMPARE) && (casWord_q != memWord_q)) begin
               mismatch_q <= 1'b1;
            end
         end
         if ((state_q == S_NEXT) && !walkLast) begin
            idx_q <= idx_q + 16'd1;
         end
      end
   end

   // Startup auto-load: switch sampled once after release
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         bootCnt_q <= 2'h0;
         bootArm_q <= 1'b1;
      end else if (bootArm_q) begin
         // Wait for the synchroniser to hold real pin levels
         if (bootCnt_q == `BOOT_SETTLE) begin
            bootArm_q <= 1'b0;
         end else begin
            bootCnt_q <= bootCnt_q + 2'd1;
         end
      end
   end

   // Request bits, refusal flag and setup area
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ctrlReq_q <= 3'h0;
         refused_q <= 1'b0;
         setup_q   <= 4'h0;
      end else begin
         if (bootArm_q && (bootCnt_q == `BOOT_SETTLE) && autoLoad) begin
            ctrlReq_q[`CTRL_READ] <= 1'b1;
         end else if (refuse) begin
            ctrlReq_q <= 3'h0;
            refused_q <= 1'b1;
         end else if ((state_q == S_NEXT) && walkLast) begin
            ctrlReq_q <= 3'h0;
         end else if (regWr && (regAddr == `REG_CTRL) && (state_q == S_IDLE)) begin
            // Writes while busy are dropped
            ctrlReq_q <= regWrData[2:0];
            if (regWrData[2:0] != 3'h0) begin
               refused_q <= 1'b0;
            end
         end
         if (regWr && (regAddr == `REG_SETUP)) begin
            setup_q <= regWrData[3:0];
         end
      end
   end

   // Read data one cycle after the strobe; unmapped reads give zero
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rdData_q <= 16'h0000;
      end else if (regRd) begin
         case (regAddr)
            `REG_CTRL:  rdData_q <= {13'h0000, ctrlReq_q};
            `REG_STAT:  rdData_q <= {8'h00, sizeB, sizeA, present, isEprom, refused_q,
                                     protect, mismatch_q, busy};
            `REG_SETUP: rdData_q <= {12'h000, setup_q};
            default:    rdData_q <= 16'h0000;
         endcase
      end else begin
         rdData_q <= 16'h0000;
      end
   end

   assign regRdData = rdData_q;
   assign busy      = (state_q != S_IDLE);

   // Port modes: console bus only on the peripheral port, switch 7 off
   assign periphConsoleBus = !perSw;
   // Peripheral port offers host command or no-protocol only
   assign periphMode = setup_q[`SETUP_PER_HI] ? `MODE_NOPROTO : `MODE_HOST;
   // Serial port takes all four modes and never the console bus
   assign serialMode = setup_q[`SETUP_SER_HI:`SETUP_SER_LO];

   assign memAddr   = memAddr_q;
   assign memWrData = memWrData_q;
   assign memWr     = memWr_q;
   assign memRd     = memRd_q;
   assign casAddr   = casAddr_q;
   assign casWrData = casWrData_q;
   assign casWrEn   = casWrEn_q;
   assign casRdEn   = casRdEn_q;

endmodule

// File: core/image_walker.v
// Purpose: Maps a linear image word index to controller and cassette addresses.
// Assumes: Index counts from zero; the cassette holds the image packed from zero.
// Notes:   Purely combinational; the caller registers the results.
`timescale 1ns/1ps
`include "cassette_regs.vh"
module image_walker #(
   parameter PROG_WORDS = 16'd15360,
   parameter EXP_WORDS  = 16'd64
) (
   // Linear position
   input  wire [15:0] wordIdx,
   // Mapped addresses
   output reg  [15:0] ctrlAddr,
   output wire [14:0] casAddr,
   output wire        lastWord,
   output wire [16:0] imageWords
);

   localparam [15:0] RO_WORDS  = `DM_RO_LAST - `DM_RO_FIRST + 16'd1;
   localparam [15:0] SET_WORDS = `DM_SETUP_LAST - `DM_SETUP_FIRST + 16'd1;
   localparam [15:0] END_PROG  = PROG_WORDS;
   localparam [15:0] END_RO    = END_PROG + RO_WORDS;
   localparam [15:0] END_SET   = END_RO + SET_WORDS;
   localparam [15:0] END_ALL   = END_SET + EXP_WORDS;

   // Program, read-only data, setup, expansion data in one batch
   always @* begin
      if (wordIdx < END_PROG) begin
         ctrlAddr = `PROG_BASE + wordIdx;
      end else if (wordIdx < END_RO) begin
         ctrlAddr = `DM_BASE + `DM_RO_FIRST + (wordIdx - END_PROG);
      end else if (wordIdx < END_SET) begin
         ctrlAddr = `DM_BASE + `DM_SETUP_FIRST + (wordIdx - END_RO);
      end else begin
         ctrlAddr = `EXP_BASE + (wordIdx - END_SET);
      end
   end

   assign casAddr    = wordIdx[14:0];
   assign lastWord   = (wordIdx == END_ALL - 16'd1);
   assign imageWords = {1'b0, END_ALL};

endmodule

// File: core/sync_bits.v
// Purpose: Two flip-flop synchroniser for a group of pin inputs.
// Assumes: Each bit is a level or is held stable while it is sampled.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/1ps
module sync_bits #(
   parameter WIDTH = 1
) (
   // Clock and reset
   input  wire             ref_clk,
   input  wire             rst,
   // Pins and synchronised levels
   input  wire [WIDTH-1:0] pinIn,
   output wire [WIDTH-1:0] syncOut
);

   reg [WIDTH-1:0] stage1_q;
   reg [WIDTH-1:0] stage2_q;

   // Two stages against metastability
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         stage1_q <= {WIDTH{1'b0}};
         stage2_q <= {WIDTH{1'b0}};
      end else begin
         stage1_q <= pinIn;
         stage2_q <= stage1_q;
      end
   end

   assign syncOut = stage2_q;

endmodule

// File: verification/cassette_model.sv
// Purpose: Behavioural memory cassette for the transfer block bench.
// Assumes: Cassette word address equals the linear image index.
// Notes:   Read data lag by ACCESS_NS; released lines show inverted noise.
`timescale 1ns/1ps
module cassette_model #(
   parameter int ACCESS_NS = 150
) (
   // Clock
   input wire logic        ref_clk,
   // Cassette pins
   input wire logic [14:0] casAddr,
   input wire logic [15:0] casWrData,
   input wire logic        casWrEn,
   input wire logic        casRdEn,
   output wire logic [15:0] casRdData
);
   logic [15:0] mem [0:32767];
   logic [15:0] lastQ = 16'h0000;

   // Store while the strobe stands; address and data are held meanwhile
   always @(posedge ref_clk) begin
      if (casWrEn) mem[casAddr] <= casWrData;
      if (casRdEn) lastQ <= mem[casAddr];
   end

   // Slow device: a stale value would hide a short wait, so lines flip when released
   assign #(ACCESS_NS) casRdData = casRdEn ? mem[casAddr] : ~lastQ;
endmodule

// File: verification/cassette_transfer_control_bench.sv
// Purpose: Self-checking bench for the cassette transfer and compare block.
// Assumes: Short image (4 program words, 2 expansion words), slow cassette.
// Notes:   Register reads are checked from a queue of expected words.
`timescale 1ns/1ps
`include "cassette_regs.vh"
module cassette_transfer_control_bench;
   localparam int PW  = 4;
   localparam int EW  = 2;
   localparam int IMG = PW + 481 + EW;
   logic        ref_clk = 1'b0;
   logic        rst = 1'b1;
   logic [3:0]  regAddr = 4'h0;
   logic [15:0] regWrData = 16'h0000;
   logic        regWr = 1'b0;
   logic        regRd = 1'b0;
   logic [15:0] memRdData = 16'h0000;
   logic        casPresent = 1'b1;
   logic        casProtectSw = 1'b0;
   logic        casIsEprom = 1'b0;
   logic        sizeA = 1'b0;
   logic        sizeB = 1'b0;
   logic        autoLoadSwitch = 1'b1;
   logic        peripheralDeviceSwitch = 1'b0;
   wire  [15:0] regRdData, memAddr, memWrData, casWrData, casRdData;
   wire  [14:0] casAddr;
   wire         memWr, memRd, casWrEn, casRdEn, periphConsoleBus, busy;
   wire  [1:0]  periphMode, serialMode;
   logic [15:0] cmem [0:65535];
   logic [15:0] expQ [$];
   logic        rdPend = 1'b0;
   logic [31:0] seed = 32'd1388;
   logic [15:0] keep;
   logic        p;
   int          num_errors = 0;
   int          comparisons = 0;
   int          cycles = 0;
   int          i, k, m;

   cassette_transfer_control #(.PROG_WORDS(16'd4), .EXP_WORDS(16'd2), .CAS_WORDS(17'd16384)) uut (
      .ref_clk(ref_clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
      .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .memAddr(memAddr),
      .memWrData(memWrData), .memWr(memWr), .memRd(memRd), .memRdData(memRdData),
      .casAddr(casAddr), .casWrData(casWrData), .casWrEn(casWrEn), .casRdEn(casRdEn),
      .casRdData(casRdData), .casPresent(casPresent), .casProtectSw(casProtectSw),
      .casIsEprom(casIsEprom), .epromSizeSelectA(sizeA), .epromSizeSelectB(sizeB),
      .autoLoadSwitch(autoLoadSwitch), .peripheralDeviceSwitch(peripheralDeviceSwitch),
      .periphConsoleBus(periphConsoleBus), .periphMode(periphMode),
      .serialMode(serialMode), .busy(busy));

   cassette_model #(.ACCESS_NS(150)) cas (
      .ref_clk(ref_clk), .casAddr(casAddr), .casWrData(casWrData),
      .casWrEn(casWrEn), .casRdEn(casRdEn), .casRdData(casRdData));

   // 20 MHz clock
   always #25 ref_clk = ~ref_clk;

   // Controller memory: data the cycle after the strobe, noise otherwise
   always @(posedge ref_clk) begin
      if (memWr) cmem[memAddr] <= memWrData;
      memRdData <= memRd ? cmem[memAddr] : ~memRdData;
   end

   // Oldest expected word meets the read data in its one-cycle slot
   always @(posedge ref_clk) begin
      if (rdPend) check(regRdData, expQ.pop_front(), "register read");
      rdPend <= regRd;
   end

   // Hang guard, well above seven whole-image passes
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 98000) begin
         num_errors++;
         $display("[ERR] %0t run did not finish", $time);
         final_report;
      end
   end

   function automatic logic [15:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[15:0];
   endfunction

   // Controller address of linear image word n
   function automatic logic [15:0] imgAddr(input int n);
      if (n < PW) return 16'(n);
      if (n < PW + 425) return 16'(32'h8000 + 6144 + n - PW);
      if (n < PW + 481) return 16'(32'h8000 + 6600 + n - PW - 425);
      return 16'(32'hF000 + n - PW - 481);
   endfunction

   task automatic check(input logic [15:0] got, input logic [15:0] exp, input string msg);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %0t %s got %h want %h", $time, msg, got, exp);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      regAddr <= a;
      regWrData <= d;
      regWr <= 1'b1;
      @(posedge ref_clk);
      regWr <= 1'b0;
      @(posedge ref_clk);
   endtask

   task automatic rd(input logic [3:0] a, input logic [15:0] exp);
      regAddr <= a;
      regRd <= 1'b1;
      expQ.push_back(exp);
      @(posedge ref_clk);
      regRd <= 1'b0;
      @(posedge ref_clk);
   endtask

   // Busy must rise promptly; the end is bounded by the hang guard
   task automatic waitOp();
      k = 0;
      while (busy !== 1'b1 && k < 12) begin
         @(posedge ref_clk);
         k++;
      end
      check(16'(busy), 16'h0001, "operation did not start");
      while (busy === 1'b1) @(posedge ref_clk);
      @(posedge ref_clk);
   endtask

   task automatic imageSame();
      for (i = 0; i < IMG; i++) check(cmem[imgAddr(i)], cas.mem[i], "image word");
   endtask

   task automatic final_report();
      if (num_errors == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   initial begin
      for (i = 0; i < IMG; i++) cas.mem[i] = rnd();
      repeat (5) @(posedge ref_clk);
      rst <= 1'b0;
      waitOp();
      autoLoadSwitch <= 1'b0;
      imageSame();
      wr(`REG_CTRL, 16'h0004);
      waitOp();
      rd(`REG_STAT, 16'h0020);
      rd(`REG_CTRL, 16'h0000);
      // One differing word; a write request during the compare is ignored
      keep = ~cas.mem[IMG - 1];
      cas.mem[IMG - 1] = keep;
      wr(`REG_CTRL, 16'h0004);
      repeat (3) @(posedge ref_clk);
      wr(`REG_CTRL, 16'h0001);
      waitOp();
      rd(`REG_STAT, 16'h0022);
      check(cas.mem[IMG - 1], keep, "cassette changed by compare");
      // Fresh controller image written out whole
      for (i = 0; i < IMG; i++) cmem[imgAddr(i)] = rnd();
      wr(`REG_CTRL, 16'h0001);
      waitOp();
      imageSame();
      rd(`REG_CTRL, 16'h0000);
      wr(`REG_CTRL, 16'h0004);
      waitOp();
      rd(`REG_STAT, 16'h0020);
      // Protected cassette refuses a write
      casProtectSw <= 1'b1;
      keep = cas.mem[0];
      cmem[imgAddr(0)] = ~keep;
      repeat (4) @(posedge ref_clk);
      wr(`REG_CTRL, 16'h0001);
      repeat (4) @(posedge ref_clk);
      rd(`REG_STAT, 16'h002C);
      rd(`REG_CTRL, 16'h0000);
      check(cas.mem[0], keep, "protected cassette written");
      // One-time cassette refuses a write for every size code
      casProtectSw <= 1'b0;
      casIsEprom <= 1'b1;
      for (m = 0; m < 4; m++) begin
         sizeA <= m[0];
         sizeB <= m[1];
         repeat (4) @(posedge ref_clk);
         wr(`REG_CTRL, 16'h0001);
         repeat (4) @(posedge ref_clk);
         rd(`REG_STAT, 16'h0038 | 16'(m << 6));
      end
      casIsEprom <= 1'b0;
      // No cassette: a read request is refused and nothing starts
      casPresent <= 1'b0;
      repeat (4) @(posedge ref_clk);
      wr(`REG_CTRL, 16'h0002);
      repeat (4) @(posedge ref_clk);
      rd(`REG_STAT, 16'h00C8);
      rd(`REG_CTRL, 16'h0000);
      casPresent <= 1'b1;
      // Every serial mode, each with a random peripheral setting
      for (m = 0; m < 4; m++) begin
         p = rnd() & 16'h0001;
         wr(`REG_SETUP, {12'h000, m[1:0], p, 1'b0});
         check(16'(serialMode), 16'(m[1:0]), "serial mode");
         check(16'(periphMode), {15'h0000, p}, "peripheral mode");
         peripheralDeviceSwitch <= p;
         repeat (4) @(posedge ref_clk);
         check(16'(periphConsoleBus), {15'h0000, ~p}, "console bus select");
      end
      repeat (3) @(posedge ref_clk);
      final_report;
   end
endmodule

bind cassette_transfer_control cassette_transfer_control_props props (
   .ref_clk(ref_clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
   .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .memWr(memWr),
   .casAddr(casAddr), .casWrData(casWrData), .casWrEn(casWrEn),
   .casProtectSw(casProtectSw), .casIsEprom(casIsEprom),
   .peripheralDeviceSwitch(peripheralDeviceSwitch), .periphConsoleBus(periphConsoleBus),
   .serialMode(serialMode), .busy(busy));

// File: verification/cassette_transfer_control_props.sv
// Purpose: Port-level assertions for the cassette transfer and compare block.
// Assumes: Pins are held stable while an operation runs; single clock domain.
// Notes:   Bound from the bench top file; watches design inputs and outputs only.
`timescale 1ns/1ps
`include "cassette_regs.vh"
module cassette_transfer_control_props (
   // Clock and reset
   input wire logic        ref_clk,
   input wire logic        rst,
   // Register port
   input wire logic [3:0]  regAddr,
   input wire logic [15:0] regWrData,
   input wire logic        regWr,
   input wire logic        regRd,
   input wire logic [15:0] regRdData,
   // Memory sides
   input wire logic        memWr,
   input wire logic [14:0] casAddr,
   input wire logic [15:0] casWrData,
   input wire logic        casWrEn,
   // Switches and modes
   input wire logic        casProtectSw,
   input wire logic        casIsEprom,
   input wire logic        peripheralDeviceSwitch,
   input wire logic        periphConsoleBus,
   input wire logic [1:0]  serialMode,
   input wire logic        busy
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   // Read data may only stand in the cycle after a read strobe
   rd_data_idle_a: assert property (!$past(regRd) |-> regRdData == 16'h0000)
      else $error("read data outside its slot");
   // No side gets written while no operation runs
   idle_no_write_a: assert property (!busy |-> !casWrEn && !memWr)
      else $error("write strobe while idle");
   // Protect pin settled: the cassette is never written
   protect_no_write_a: assert property (casProtectSw && $past(casProtectSw, 3) |-> !casWrEn)
      else $error("cassette written while protected");
   // One-time cassette: never written by the block
   eprom_no_write_a: assert property (casIsEprom && $past(casIsEprom, 3) |-> !casWrEn)
      else $error("one-time cassette written");
   // Cassette write strobe is exactly four cycles long
   wr_pulse_len_a: assert property ($rose(casWrEn) |-> casWrEn[*4] ##1 !casWrEn)
      else $error("cassette write pulse length wrong");
   // Address and data hold while the write strobe stands
   wr_hold_a: assert property (casWrEn && $past(casWrEn) |-> $stable(casAddr) && $stable(casWrData))
      else $error("cassette word moved during write");
   // Console bus follows the settled switch inverted
   console_bus_a: assert property (peripheralDeviceSwitch == $past(peripheralDeviceSwitch)
      && peripheralDeviceSwitch == $past(peripheralDeviceSwitch, 2)
      |-> periphConsoleBus == !peripheralDeviceSwitch)
      else $error("console bus select wrong");
   // Serial mode takes the written setup field one cycle on
   serial_mode_a: assert property ($past(regWr && regAddr == `REG_SETUP)
      |-> serialMode == $past(regWrData[`SETUP_SER_HI:`SETUP_SER_LO]))
      else $error("serial mode not updated");

   cover property ($rose(busy));
   cover property ($rose(casWrEn));
   cover property (memWr);
endmodule
